// [core/rbp_regs.svh]
// register indices, field positions and reset values
// for the receive-buffer identifier and pin-control bank.
// byte address on apb is four times the index.
`ifndef RBP_REGS_SVH
`define RBP_REGS_SVH

// register indices
`define RBP_IDX_PIN_CTRL 10'h00c
`define RBP_IDX_RX0_SIDH 10'h061
`define RBP_IDX_RX0_SIDL 10'h062
`define RBP_IDX_RX0_EID8 10'h063
`define RBP_IDX_RX0_EID0 10'h064
`define RBP_IDX_RX1_SIDH 10'h071
`define RBP_IDX_RX1_SIDL 10'h072
`define RBP_IDX_RX1_EID8 10'h073
`define RBP_IDX_RX1_EID0 10'h074
`define RBP_IDX_IRQ_STAT 10'h080
`define RBP_IDX_IRQ_MASK 10'h081

// buffer index layout: base nibble, byte select
`define RBP_RX0_BASE     6'h18
`define RBP_RX1_BASE     6'h1c

// pin control field positions
`define RBP_PIN_STATE_LSB 4
`define RBP_PIN_ENA_LSB   2
`define RBP_PIN_MODE_LSB  0
`define RBP_PIN_CTRL_RST  6'h00

// std id low byte field positions
`define RBP_SIDL_SID_LSB  5
`define RBP_SIDL_SRR_BIT  4
`define RBP_SIDL_IDE_BIT  3
`define RBP_SIDL_EID_LSB  0

// interrupt status / mask
`define RBP_IRQ_RST       2'h0

`endif

// [core/rbp_pkg.sv]
// types shared by the identifier bank and its buffers.
// assumes rbp_regs.svh for all numeric layout.
package rbp_pkg;

    // one received identifier as the receiver hands it over
    typedef struct packed {
        logic [10:0] standard_identifier;   // standard identifier
        logic        rtr;   // standard remote request
        logic        ext;   // extended frame
        logic [17:0] extended_identifier;   // extended identifier
    } rbp_msg_type;

    // pin control, laid out as in the register bits 5..0
    typedef struct packed {
        logic [1:0] state;  // output level, per pin
        logic [1:0] enable; // pin driven when set
        logic [1:0] mode;   // 1 = interrupt, 0 = output
    } rbp_pin_ctrl_type;

    // apb request as seen by the register decode
    typedef struct packed {
        logic [9:0]  index;
        logic        write;
        logic [31:0] wdata;
        logic [3:0]  strb;
    } rbp_apb_req_type;

endpackage

// [core/rbp_id_store.sv]
// identifier store of one receive buffer.
// assumes load is a one-cycle pulse on pclk with msg valid.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_regs.svh"

module rbp_id_store (
    input  wire logic                pclk,  // bus clock
    input  wire logic                load,  // valid message loaded
    input  wire rbp_pkg::rbp_msg_type msg,  // identifier of it
    input  wire logic [1:0]          sel,   // byte 0..3
    output logic [7:0]               rdata  // selected byte
);

    rbp_pkg::rbp_msg_type msg_q;

    // contents undefined after reset, so no reset term
    always_ff @(posedge pclk) begin
        if (load) begin
            msg_q <= msg;
        end
    end

    // byte view of the stored identifier
    function automatic logic [7:0] id_byte(
        input rbp_pkg::rbp_msg_type m,
        input logic [1:0]           s
    );
        logic [7:0] b;
        b = 8'h00;
        case (s)
            2'd0: b = m.standard_identifier[10:3];
            2'd1: begin
                b[`RBP_SIDL_SID_LSB +: 3] = m.standard_identifier[2:0];
                b[`RBP_SIDL_SRR_BIT]      = m.rtr;
                b[`RBP_SIDL_IDE_BIT]      = m.ext;
                b[`RBP_SIDL_EID_LSB +: 2] = m.extended_identifier[17:16];
            end                                          // bit 2 stays zero
            2'd2: b = m.extended_identifier[15:8];
            default: b = m.extended_identifier[7:0];
        endcase
        return b;
    endfunction

    assign rdata = id_byte(msg_q, sel);

endmodule // rbp_id_store
`default_nettype wire

// [core/rbp_top.sv]
// buffer-full pin control and receive identifier registers.
// assumes an apb master on pclk and a receiver that pulses
// rxN_load with the identifier of each valid stored message.
//
// Operation
// - pin control register at 0Ch: state, enable and mode bits per pin.
// - first identifier byte at 61h and 71h, read-only, undefined after reset.
// - first identifier byte holds standard identifier bits 10 to 3.
// - second identifier byte at 62h and 72h, read-only, undefined after reset.
// - second byte bits 7 to 5 hold standard identifier bits 2 to 0.
// - second byte bit 4 is standard remote request flag.
// - second byte bit 3 flags an extended frame.
// - second byte bit 2 always reads zero.
// - second byte bits 1 to 0 hold extended identifier bits 17 and 16.
// - third byte at 63h and 73h holds extended identifier bits 15 to 8.
// - extended identifier bits 7 to 0 read at 64h and 74h.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_regs.svh"

module rbp_top (
    input  wire logic                 pclk,        // bus clock, 100 mhz
    input  wire logic                 presetn,     // async reset, low
    input  wire logic                 psel,        // apb select
    input  wire logic                 penable,     // apb access phase
    input  wire logic                 pwrite,      // apb direction
    input  wire logic [11:0]          paddr,       // apb byte address
    input  wire logic [31:0]          pwdata,      // apb write data
    input  wire logic [3:0]           pstrb,       // apb byte lanes
    output logic [31:0]               prdata,      // apb read data
    output logic                      pready,      // apb ready
    output logic                      pslverr,     // unmapped access
    input  wire logic                 rx0_load,    // msg into buffer 0
    input  wire rbp_pkg::rbp_msg_type rx0_msg,     // its identifier
    input  wire logic                 rx1_load,    // msg into buffer 1
    input  wire rbp_pkg::rbp_msg_type rx1_msg,     // its identifier
    output logic                      buffer0_full_pin_o,  // pin level
    output logic                      buffer0_full_pin_oe, // pin driven
    output logic                      buffer1_full_pin_o,  // pin level
    output logic                      buffer1_full_pin_oe, // pin driven
    output logic                      irq          // level interrupt
);

    // state
    rbp_pkg::rbp_pin_ctrl_type pin_ctrl_q;
    rbp_pkg::rbp_pin_ctrl_type pin_ctrl_d;
    logic [1:0]                irq_stat_q;
    logic [1:0]                irq_stat_d;
    logic [1:0]                irq_mask_q;
    logic [1:0]                irq_mask_d;
    logic [31:0]               prdata_q;
    logic [31:0]               prdata_d;
    logic                      pready_q;
    logic                      pslverr_q;
    logic                      pslverr_d;
    logic                      pslverr_o_q;
    logic                      irq_q;
    logic [1:0]                pin_o_q;
    logic [1:0]                pin_o_d;
    logic [1:0]                pin_oe_q;
    logic [1:0]                pin_oe_d;

    // request view of the bus
    rbp_pkg::rbp_apb_req_type req;
    logic                      setup;
    logic                      access;
    logic                      wr_en;
    logic                      lane0;

    // decode
    logic                      hit_pin;
    logic                      hit_stat;
    logic                      hit_mask;
    logic                      hit_rx0;
    logic                      hit_rx1;
    logic                      hit_any;
    logic [1:0]                id_sel;

    // read data
    logic [7:0]                rx0_byte;
    logic [7:0]                rx1_byte;
    logic [7:0]                rd_byte;
    rbp_pkg::rbp_pin_ctrl_type pin_view;

    // events and write strobes
    logic [1:0]                rx_load;
    logic [1:0]                stat_clr;

    // index match, used by the pin control, status and mask decode
    function automatic logic idx_is(
        input logic [9:0] idx,
        input logic [9:0] ref_idx
    );
        return idx == ref_idx;
    endfunction

    // buffer match: upper index bits select the buffer,
    // low two bits 01..11 and the wrap to 00 of the next
    // nibble select the byte; only 1..4 are mapped
    function automatic logic rx_hit(
        input logic [9:0] idx,
        input logic [9:0] first
    );
        return (idx >= first) && (idx <= first + 10'h003);
    endfunction

    // bus request fields
    assign req.index = paddr[11:2];
    assign req.write = pwrite;
    assign req.wdata = pwdata;
    assign req.strb  = pstrb;

    // phases: decode in setup, commit in access
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready_q;
    assign wr_en  = access & req.write & ~pslverr_q;
    assign lane0  = req.strb[0];

    // register decode
    assign hit_pin  = idx_is(req.index, `RBP_IDX_PIN_CTRL);
    assign hit_stat = idx_is(req.index, `RBP_IDX_IRQ_STAT);
    assign hit_mask = idx_is(req.index, `RBP_IDX_IRQ_MASK);
    assign hit_rx0  = rx_hit(req.index, `RBP_IDX_RX0_SIDH);
    assign hit_rx1  = rx_hit(req.index, `RBP_IDX_RX1_SIDH);
    assign hit_any  = hit_pin | hit_stat | hit_mask
                    | hit_rx0 | hit_rx1;

    // byte select: 61h..64h map to 0..3
    assign id_sel = 2'(req.index[1:0] - 2'd1);

    // the two identifier stores
    assign rx_load = {rx1_load, rx0_load};

    rbp_id_store u_rx0_store (
        .pclk  (pclk),
        .load  (rx0_load),
        .msg   (rx0_msg),
        .sel   (id_sel),
        .rdata (rx0_byte)
    );

    rbp_id_store u_rx1_store (
        .pclk  (pclk),
        .load  (rx1_load),
        .msg   (rx1_msg),
        .sel   (id_sel),
        .rdata (rx1_byte)
    );

    // state bits hide behind interrupt mode on read
    assign pin_view.state  = pin_ctrl_q.state
                           & ~pin_ctrl_q.mode;
    assign pin_view.enable = pin_ctrl_q.enable;
    assign pin_view.mode   = pin_ctrl_q.mode;

    // read mux; unmapped and reserved bits read zero
    assign rd_byte = hit_pin  ? {2'b00, pin_view} :
                     hit_stat ? {6'h00, irq_stat_q} :
                     hit_mask ? {6'h00, irq_mask_q} :
                     hit_rx0  ? rx0_byte :
                     hit_rx1  ? rx1_byte :
                     8'h00;

    // read data is latched in setup so prdata is a flop;
    // the cost is one cycle of decode, not a wait state
    assign prdata_d  = setup ? {24'h000000, rd_byte}
                             : prdata_q;
    assign pslverr_d = setup ? ~hit_any : pslverr_q;

    // pin control write: identifier bytes ignore writes
    assign pin_ctrl_d = (wr_en & hit_pin & lane0)
                      ? rbp_pkg::rbp_pin_ctrl_type'(req.wdata[5:0])
                      : pin_ctrl_q;

    // mask write
    assign irq_mask_d = (wr_en & hit_mask & lane0)
                      ? req.wdata[1:0]
                      : irq_mask_q;

    // write one to clear status
    assign stat_clr = (wr_en & hit_stat & lane0)
                    ? req.wdata[1:0]
                    : 2'b00;

    // a load in the clearing cycle wins over the clear
    assign irq_stat_d = (irq_stat_q & ~stat_clr)
                      | rx_load;

    // pin drive: enable gates the driver, mode picks
    // the source; interrupt level is active low
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_oe_d[i] = pin_ctrl_d.enable[i];
            if (pin_ctrl_d.mode[i]) begin
                pin_o_d[i] = ~irq_stat_d[i];
            end else begin
                pin_o_d[i] = pin_ctrl_d.state[i];
            end
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ctrl_q <= rbp_pkg::rbp_pin_ctrl_type'(`RBP_PIN_CTRL_RST);
            irq_mask_q <= `RBP_IRQ_RST;
            irq_stat_q <= `RBP_IRQ_RST;
        end else begin
            pin_ctrl_q <= pin_ctrl_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
        end
    end

    // bus answer: ready in the access phase only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            pslverr_o_q <= 1'b0;
            prdata_q    <= 32'h00000000;
        end else begin
            pready_q    <= setup;
            pslverr_q   <= pslverr_d;
            pslverr_o_q <= setup & ~hit_any; // high with pready only
            prdata_q    <= prdata_d;
        end
    end

    // pins and interrupt come from flops fed by next
    // state, so they move on the same edge as the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o_q  <= 2'b00;
            pin_oe_q <= 2'b00;
            irq_q    <= 1'b0;
        end else begin
            pin_o_q  <= pin_o_d;
            pin_oe_q <= pin_oe_d;
            irq_q    <= |(irq_stat_d & irq_mask_d);
        end
    end

    // outputs
    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_o_q;
    assign buffer0_full_pin_o  = pin_o_q[0];
    assign buffer0_full_pin_oe = pin_oe_q[0];
    assign buffer1_full_pin_o  = pin_o_q[1];
    assign buffer1_full_pin_oe = pin_oe_q[1];
    assign irq                 = irq_q;

endmodule // rbp_top
`default_nettype wire

// [tb/rbp_top_chk.sv]
// checker for rbp_top: apb answer, pin control and the second identifier byte of buffer 1.
// assumes one pclk domain with presetn async low; bound below.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_regs.svh"

module rbp_top_chk (
    input wire logic                 pclk,                // clk
    input wire logic                 presetn,             // rst
    input wire logic                 psel,                // sel
    input wire logic                 penable,             // en
    input wire logic                 pwrite,              // dir
    input wire logic [11:0]          paddr,               // addr
    input wire logic [31:0]          pwdata,              // wdata
    input wire logic [3:0]           pstrb,               // lanes
    input wire logic [31:0]          prdata,              // rdata
    input wire logic                 pready,              // ready
    input wire logic                 pslverr,             // err
    input wire logic                 rx0_load,            // load 0
    input wire logic                 rx1_load,            // load 1
    input wire rbp_pkg::rbp_msg_type rx1_msg,             // msg 1
    input wire logic                 buffer0_full_pin_o,  // pin 0
    input wire logic                 buffer0_full_pin_oe, // oe 0
    input wire logic                 buffer1_full_pin_o,  // pin 1
    input wire logic                 buffer1_full_pin_oe, // oe 1
    input wire logic                 irq                  // irq
);
    // shadows of software writes; pins follow ctl_q, readback lags it one cycle
    logic [5:0]           ctl_q, ctl_dly_q;
    logic [1:0]           msk_q;
    rbp_pkg::rbp_msg_type m1_q;
    wire [9:0]  idx    = paddr[11:2];
    wire        rd_ok  = pready && !pwrite;
    wire        wr_ok  = psel && penable && pready && pwrite && pstrb[0];
    wire        mapped = idx inside {10'h00c, [10'h061:10'h064], [10'h071:10'h074], 10'h080, 10'h081};
    wire [7:0]  sidl1  = {m1_q.standard_identifier[2:0], m1_q.rtr, m1_q.ext, 1'b0, m1_q.extended_identifier[17:16]};

    // shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q     <= 6'h00;
            ctl_dly_q <= 6'h00;
            msk_q     <= 2'h0;
        end else begin
            if (wr_ok && idx == `RBP_IDX_PIN_CTRL) ctl_q <= pwdata[5:0];
            if (wr_ok && idx == `RBP_IDX_IRQ_MASK) msk_q <= pwdata[1:0];
            ctl_dly_q <= ctl_q;
        end
    end

    // identifier has no reset, as in the device
    always_ff @(posedge pclk) begin
        if (rx1_load) m1_q <= rx1_msg;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_one_ready;
        pready ##1 !pready;
    endsequence

    AST_RDY_ONE: assert property (s_setup |=> s_one_ready)
        else $error("ready not one cycle after setup");
    AST_UNMAPPED: assert property (rd_ok && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    AST_CTRL_RD: assert property (rd_ok && idx == `RBP_IDX_PIN_CTRL |-> prdata[7:0] == {2'b00, ctl_dly_q[5:4] & ~ctl_dly_q[1:0], ctl_dly_q[3:0]})
        else $error("pin control readback wrong");
    AST_PIN_OE: assert property (buffer0_full_pin_oe == ctl_q[2] && buffer1_full_pin_oe == ctl_q[3])
        else $error("pin drive enable wrong");
    AST_PIN_OUT: assert property (ctl_q[3] && !ctl_q[1] |-> buffer1_full_pin_o == ctl_q[5])
        else $error("output pin level wrong");
    AST_PIN_IRQ: assert property (rx0_load && ctl_q[2] && ctl_q[0] |=> buffer0_full_pin_oe && !buffer0_full_pin_o)
        else $error("pin not low after load");
    AST_IRQ: assert property (rx1_load && msk_q[1] |=> irq)
        else $error("irq not raised after load");
    AST_SIDL1: assert property (rd_ok && idx == `RBP_IDX_RX1_SIDL |-> prdata[7:0] == $past(sidl1))
        else $error("second identifier byte wrong");
endmodule // rbp_top_chk

bind rbp_top rbp_top_chk rbp_top_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .rx0_load, .rx1_load, .rx1_msg, .buffer0_full_pin_o, .buffer0_full_pin_oe,
    .buffer1_full_pin_o, .buffer1_full_pin_oe, .irq);
`default_nettype wire

// [tb/rbp_rx_model.sv]
// receiver stand-in: one load strobe per request, per buffer.
// assumes one-cycle requests from the bench on pclk.
`timescale 1ns/1ps
`default_nettype none

module rbp_rx_model (
    input  wire logic                 pclk,     // clk
    input  wire logic                 presetn,  // rst
    input  wire logic [1:0]           req,      // load request
    input  wire rbp_pkg::rbp_msg_type msg_in,   // identifier
    output var  logic                 rx0_load, // strobe 0
    output var  rbp_pkg::rbp_msg_type rx0_msg,  // msg 0
    output var  logic                 rx1_load, // strobe 1
    output var  rbp_pkg::rbp_msg_type rx1_msg   // msg 1
);
    // outside a strobe the msg toggles, so late sampling reads junk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx0_load <= 1'b0;
            rx1_load <= 1'b0;
            rx0_msg  <= '0;
            rx1_msg  <= '0;
        end else begin
            rx0_load <= req[0];
            rx1_load <= req[1];
            rx0_msg  <= req[0] ? msg_in : ~rx0_msg;
            rx1_msg  <= req[1] ? msg_in : ~rx1_msg;
        end
    end
endmodule // rbp_rx_model
`default_nettype wire

// [tb/rbp_top_tb.sv]
// bench for rbp_top: apb tasks, receiver model, expected values.
// assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "rbp_regs.svh"

module rbp_top_tb;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [3:0]           pstrb;
    logic                 rx0_load, rx1_load, irq, o0, oe0, o1, oe1;
    logic [1:0]           req;
    logic [7:0]           w;
    logic [7:0]           ctl_list [6] = '{8'h3c, 8'h2c, 8'h1c, 8'hff, 8'h33, 8'h0f};
    rbp_pkg::rbp_msg_type msg, rx0_msg, rx1_msg;
    rbp_pkg::rbp_msg_type m_a = {11'h5a3, 1'b1, 1'b0, 18'h3a5c3};
    rbp_pkg::rbp_msg_type m_b = {11'h2bc, 1'b0, 1'b1, 18'h15a3c};
    rbp_pkg::rbp_msg_type m_c = {11'h7ff, 1'b0, 1'b1, 18'h2c0f1};
    int                   errors, compares;

    rbp_top rbp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .rx0_load, .rx0_msg, .rx1_load, .rx1_msg, .buffer0_full_pin_o(o0), .buffer0_full_pin_oe(oe0),
        .buffer1_full_pin_o(o1), .buffer1_full_pin_oe(oe1), .irq);
    rbp_rx_model rbp_rx_model_i (.pclk, .presetn, .req, .msg_in(msg), .rx0_load, .rx0_msg, .rx1_load, .rx1_msg);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; waits on pready, no fixed latency assumed
    task automatic xfer(input logic [9:0] idx, input logic wr, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            give_verdict();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] idb(input rbp_pkg::rbp_msg_type m, input int k);
        case (k)
            0: return m.standard_identifier[10:3];
            1: return {m.standard_identifier[2:0], m.rtr, m.ext, 1'b0, m.extended_identifier[17:16]};
            2: return m.extended_identifier[15:8];
            default: return m.extended_identifier[7:0];
        endcase
    endfunction

    task automatic read_ids(input logic [9:0] base, input rbp_pkg::rbp_msg_type m);
        for (int k = 0; k < 4; k++) begin
            xfer(base + 10'(k), 1'b0, 32'h0);
            check(rd, {24'h0, idb(m, k)});
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard, far beyond the hundred or so cycles needed
    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    initial begin
        errors   = 0;
        compares = 0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        pstrb    = 4'hf;
        req      = 2'h0;
        msg      = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check({oe1, oe0, irq}, 3'h0);
        xfer(`RBP_IDX_PIN_CTRL, 1'b0, 32'h0);
        check(rd, 32'h0);
        xfer(10'h3ff, 1'b0, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        // every pin mode; state bits hidden in interrupt mode
        foreach (ctl_list[i]) begin
            w = ctl_list[i];
            xfer(`RBP_IDX_PIN_CTRL, 1'b1, {24'h0, w});
            xfer(`RBP_IDX_PIN_CTRL, 1'b0, 32'h0);
            check(rd, {26'h0, w[5:4] & ~w[1:0], w[3:0]});
            check({oe1, oe0}, w[3:2]);
            check({o1 & w[3], o0 & w[2]}, {w[3] & (w[1] | w[5]), w[2] & (w[0] | w[4])});
        end
        xfer(`RBP_IDX_IRQ_MASK, 1'b1, 32'h3);
        @(posedge pclk);
        msg <= m_a;
        req <= 2'b01;
        @(posedge pclk);
        req <= 2'b00;
        repeat (3) @(posedge pclk);
        check({o1, o0, irq}, 3'b101);
        xfer(`RBP_IDX_RX0_SIDH, 1'b1, 32'hff);
        read_ids(`RBP_IDX_RX0_SIDH, m_a);
        // back-to-back loads into buffer 1: the second one stays
        @(posedge pclk);
        msg <= m_b;
        req <= 2'b10;
        @(posedge pclk);
        msg <= m_c;
        @(posedge pclk);
        req <= 2'b00;
        xfer(`RBP_IDX_RX1_EID8, 1'b1, 32'h0);
        read_ids(`RBP_IDX_RX1_SIDH, m_c);
        check({o1, o0, irq}, 3'b001);
        xfer(`RBP_IDX_IRQ_STAT, 1'b0, 32'h0);
        check(rd, 32'h3);
        xfer(`RBP_IDX_IRQ_STAT, 1'b1, 32'h1);
        xfer(`RBP_IDX_IRQ_STAT, 1'b0, 32'h0);
        check(rd, 32'h2);
        check({o1, o0, irq}, 3'b011);
        xfer(`RBP_IDX_IRQ_STAT, 1'b1, 32'h2);
        xfer(`RBP_IDX_IRQ_MASK, 1'b0, 32'h0);
        check(rd, 32'h3);
        check({o1, o0, irq}, 3'b110);
        give_verdict();
    end
endmodule // rbp_top_tb
`default_nettype wire
